//--- rtl/lpw_pkg.sv
// Package: register map, fields, reset values and timing counts for the power-mode controller
package lpw_pkg;
  localparam int CLK_HZ = 25000000;
  localparam int SLEEP_RESUME_NS = 15000;
  localparam int HIB_RESUME_NS = 100000;
  localparam int BOOST_SW_HZ = 400000;
  localparam int SLEEP_RESUME_CYC = (SLEEP_RESUME_NS / 40) - 1;
  // Two cycles off where sleep takes one so hibernate resume stays strictly under its bound
  localparam int HIB_RESUME_CYC = (HIB_RESUME_NS / 40) - 2;
  localparam int BOOST_DIV_CYC = CLK_HZ / BOOST_SW_HZ;
  localparam int CNT_W = 12;
  localparam logic [CNT_W-1:0] SLEEP_RESUME_CNT = CNT_W'(SLEEP_RESUME_CYC);
  localparam logic [CNT_W-1:0] HIB_RESUME_CNT = CNT_W'(HIB_RESUME_CYC);
  localparam logic [CNT_W-1:0] BOOST_DIV_CNT = CNT_W'(BOOST_DIV_CYC - 1);
  localparam logic [CNT_W-1:0] REFRESH_PERIOD_RST = 12'h800;

  localparam logic [7:0] ADR_MODE = 8'h00;
  localparam logic [7:0] ADR_WAKE_EN = 8'h04;
  localparam logic [7:0] ADR_BOOST = 8'h08;
  localparam logic [7:0] ADR_STATUS = 8'h0C;
  localparam logic [7:0] ADR_WAKE_SRC = 8'h10;
  localparam logic [7:0] ADR_REFRESH = 8'h14;

  localparam logic [1:0] MODE_ACTIVE = 2'h0;
  localparam logic [1:0] MODE_ALT = 2'h1;
  localparam logic [1:0] MODE_SLEEP = 2'h2;
  localparam logic [1:0] MODE_HIB = 2'h3;

  localparam int WK_PERIPH = 0;
  localparam int WK_SUPERV = 1;
  localparam int WK_TIMER = 2;
  localparam int WK_PIN = 3;
  localparam int WK_EXTERNAL_RESET_PIN = 4;
  localparam int WK_WDOG = 5;
  localparam int WK_PRECISE_LOW_VOLTAGE_RESET = 6;
  localparam int WK_N = 7;
  localparam logic [WK_N-1:0] WAKE_EN_RST = 7'h7F;

  localparam int BST_SEL_LSB = 0;
  localparam int BST_SEL_W = 6;
  localparam int BST_STBY_BIT = 6;
  localparam int BST_HIB_BIT = 7;
  localparam int FAST_CLK_BIT = 8;
  localparam logic [5:0] BST_SEL_MAX = 6'h20;
  localparam logic [5:0] BST_SEL_RST = 6'h0F;

  typedef enum logic [2:0] {
    ST_ACTIVE = 3'b000,
    ST_SLEEP = 3'b001,
    ST_HIB = 3'b010,
    ST_WAKE_SLP = 3'b011,
    ST_WAKE_HIB = 3'b100,
    ST_REFRESH = 3'b101
  } lpw_state_t;
endpackage

//--- rtl/lpw_ctrl.sv
// Power-mode sequencer with wakeup routing, boost mode control and Wishbone registers
// What this block does
// - Sleep resume completes within 15 us.
// - Wait for regulator ready, or the resume count to run out, before returning global mode to active.
// - Hibernate keeps configuration and SRAM, gates nearly everything else.
// - Digital outputs and pin interrupt settings hold during hibernate.
// - Only an I/O pin interrupt wakes from hibernate.
// - Hibernate resume completes in under 100 us.
// - Any enabled wakeup interrupt or reset returns to active from sleep.
// - Firmware enables peripheral, supervisor, timer and pin wake sources.
// - Central periodic timer raises recurring wake interrupts.
// - External reset, watchdog and precise low-voltage reset are wake sources.
// - Boost output 1.8 V to 5.0 V in 100 mV steps.
// - Boost has active and standby modes.
// - Boost standby in sleep needs periodic wake for active refresh.
// - Startup clock is 12 MHz unless fast startup option set.
// - Boost switches at about 403 kHz from a divide-by-62 on clk_i (integer CLK_HZ / BOOST_SW_HZ).
// - Global mode defaults to active after boot.
// - Any wakeup enables the processor regardless of template.
//
// The register addresses and the Wishbone register port were left to the implementer.
`timescale 1ns/1ps
module lpw_ctrl (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [3:0] wb_sel_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic periph_irq_i,
  input wire logic supervisor_irq_i,
  input wire logic timer_tick_i,
  input wire logic pin_irq_i,
  input wire logic external_reset_pin_i,
  input wire logic watchdog_reset_i,
  input wire logic precise_low_voltage_reset_i,
  input wire logic regulator_ready_i,
  input wire logic cpu_template_en_i,
  output logic [1:0] global_mode_o,
  output logic cpu_en_o,
  output logic retain_hold_o,
  output logic periph_gate_o,
  output logic regulator_on_o,
  output logic [5:0] boost_output_node_sel_o,
  output logic boost_active_o,
  output logic boost_clk_en_o,
  output logic timer_wake_irq_o,
  output logic fast_startup_clock_option_o,
  output logic startup_clk_12m_o
);
  lpw_pkg::lpw_state_t st_r, st_nxt;
  logic [lpw_pkg::CNT_W-1:0] cnt_r, cnt_nxt;
  logic [lpw_pkg::CNT_W-1:0] rtimer_r, rtimer_nxt;
  logic [lpw_pkg::CNT_W-1:0] refresh_per_r, refresh_per_nxt;
  logic [lpw_pkg::CNT_W-1:0] bdiv_r, bdiv_nxt;
  logic [1:0] mode_r, mode_nxt;
  logic [lpw_pkg::WK_N-1:0] wake_en_r, wake_en_nxt;
  logic [lpw_pkg::WK_N-1:0] wake_src_r, wake_src_nxt;
  logic [5:0] bsel_r, bsel_nxt;
  logic bstby_r, bstby_nxt;
  logic bhib_r, bhib_nxt;
  logic fast_r, fast_nxt;
  logic [31:0] dat_r, dat_nxt;
  logic ack_r, ack_nxt;
  logic cpu_r, cpu_nxt;
  logic ret_r, ret_nxt;
  logic gate_r, gate_nxt;
  logic reg_on_r, reg_on_nxt;
  logic bact_r, bact_nxt;
  logic bclk_r, bclk_nxt;
  logic tirq_r, tirq_nxt;
  logic tmpl_r, tmpl_nxt;
  logic clk12_r, clk12_nxt;
  logic [lpw_pkg::WK_N-1:0] ev;
  logic [lpw_pkg::WK_N-1:0] wake_hit;
  logic wr, rd;
  logic sleep_wake;

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d, input logic [3:0] sel);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        r[8*i +: 8] = d[8*i +: 8];
      end
    end
    return r;
  endfunction

  function automatic logic is_low_power(input lpw_pkg::lpw_state_t s);
    return (s == lpw_pkg::ST_SLEEP) || (s == lpw_pkg::ST_HIB);
  endfunction

  // Sources allowed to wake from each low-power state
  function automatic logic [lpw_pkg::WK_N-1:0] wake_mask(input lpw_pkg::lpw_state_t s);
    logic [lpw_pkg::WK_N-1:0] msk;
    msk = '0;
    if (s == lpw_pkg::ST_HIB) begin
      msk[lpw_pkg::WK_PIN] = 1'b1;
    end else if (s == lpw_pkg::ST_SLEEP || s == lpw_pkg::ST_REFRESH) begin
      msk = '1;
    end
    return msk;
  endfunction

  always_comb begin
    ev = '0;
    ev[lpw_pkg::WK_PERIPH] = periph_irq_i;
    ev[lpw_pkg::WK_SUPERV] = supervisor_irq_i;
    ev[lpw_pkg::WK_TIMER] = timer_tick_i;
    ev[lpw_pkg::WK_PIN] = pin_irq_i;
    ev[lpw_pkg::WK_EXTERNAL_RESET_PIN] = external_reset_pin_i;
    ev[lpw_pkg::WK_WDOG] = watchdog_reset_i;
    ev[lpw_pkg::WK_PRECISE_LOW_VOLTAGE_RESET] = precise_low_voltage_reset_i;
    wake_hit = ev & wake_en_r;
    sleep_wake = |wake_hit;
    wr = wb_cyc_i && wb_stb_i && wb_we_i && !ack_r;
    rd = wb_cyc_i && wb_stb_i && !wb_we_i && !ack_r;
  end

  // Bus and configuration registers
  always_comb begin
    logic [31:0] m;
    m = '0;
    mode_nxt = mode_r;
    wake_en_nxt = wake_en_r;
    bsel_nxt = bsel_r;
    bstby_nxt = bstby_r;
    bhib_nxt = bhib_r;
    fast_nxt = fast_r;
    refresh_per_nxt = refresh_per_r;
    wake_src_nxt = wake_src_r;
    dat_nxt = dat_r;
    ack_nxt = wb_cyc_i && wb_stb_i && !ack_r;
    if (wr) begin
      unique case (wb_adr_i)
        lpw_pkg::ADR_MODE: begin
          m = merge({30'h0, mode_r}, wb_dat_i, wb_sel_i);
          mode_nxt = m[1:0];
        end
        lpw_pkg::ADR_WAKE_EN: begin
          m = merge({25'h0, wake_en_r}, wb_dat_i, wb_sel_i);
          wake_en_nxt = m[lpw_pkg::WK_N-1:0];
        end
        lpw_pkg::ADR_BOOST: begin
          m = merge({23'h0, fast_r, bhib_r, bstby_r, bsel_r}, wb_dat_i, wb_sel_i);
          if (m[lpw_pkg::BST_SEL_LSB +: lpw_pkg::BST_SEL_W] <= lpw_pkg::BST_SEL_MAX) begin
            bsel_nxt = m[lpw_pkg::BST_SEL_LSB +: lpw_pkg::BST_SEL_W];
          end
          bstby_nxt = m[lpw_pkg::BST_STBY_BIT];
          bhib_nxt = m[lpw_pkg::BST_HIB_BIT];
          fast_nxt = m[lpw_pkg::FAST_CLK_BIT];
        end
        lpw_pkg::ADR_WAKE_SRC: begin
          m = merge(32'h0, wb_dat_i, wb_sel_i);
          wake_src_nxt = wake_src_r & ~m[lpw_pkg::WK_N-1:0];
        end
        lpw_pkg::ADR_REFRESH: begin
          m = merge({20'h0, refresh_per_r}, wb_dat_i, wb_sel_i);
          refresh_per_nxt = m[lpw_pkg::CNT_W-1:0];
        end
        default: begin
        end
      endcase
    end
    if (rd) begin
      unique case (wb_adr_i)
        lpw_pkg::ADR_MODE: dat_nxt = {30'h0, mode_r};
        lpw_pkg::ADR_WAKE_EN: dat_nxt = {25'h0, wake_en_r};
        lpw_pkg::ADR_BOOST: dat_nxt = {23'h0, fast_r, bhib_r, bstby_r, bsel_r};
        lpw_pkg::ADR_STATUS: dat_nxt = {26'h0, bact_r, cpu_r, 1'b0, st_r};
        lpw_pkg::ADR_WAKE_SRC: dat_nxt = {25'h0, wake_src_r};
        lpw_pkg::ADR_REFRESH: dat_nxt = {20'h0, refresh_per_r};
        default: dat_nxt = 32'h0;
      endcase
    end
    // Hardware completes the return to active by writing the mode back
    if (st_r != lpw_pkg::ST_ACTIVE && st_nxt == lpw_pkg::ST_ACTIVE) begin
      mode_nxt = lpw_pkg::MODE_ACTIVE;
    end
    // Latch wake cause; set beats a same-cycle clear
    wake_src_nxt = wake_src_nxt | (wake_hit & wake_mask(st_r));
  end

  // Power-mode sequencer
  always_comb begin
    st_nxt = st_r;
    cnt_nxt = cnt_r;
    rtimer_nxt = rtimer_r;
    cpu_nxt = cpu_r;
    tmpl_nxt = cpu_template_en_i;
    unique case (st_r)
      lpw_pkg::ST_ACTIVE: begin
        // Template acts on change only, so the enable forced by a wakeup survives
        if (cpu_template_en_i != tmpl_r) begin
          cpu_nxt = cpu_template_en_i;
        end
        if (mode_r == lpw_pkg::MODE_SLEEP) begin
          st_nxt = lpw_pkg::ST_SLEEP;
          rtimer_nxt = refresh_per_r;
        end else if (mode_r == lpw_pkg::MODE_HIB) begin
          st_nxt = lpw_pkg::ST_HIB;
        end
      end
      lpw_pkg::ST_SLEEP: begin
        cpu_nxt = 1'b0;
        if (rtimer_r != '0) begin
          rtimer_nxt = rtimer_r - 1'b1;
        end
        if (sleep_wake) begin
          st_nxt = lpw_pkg::ST_WAKE_SLP;
          cnt_nxt = lpw_pkg::SLEEP_RESUME_CNT;
        end else if (bstby_r && rtimer_r == '0) begin
          st_nxt = lpw_pkg::ST_REFRESH;
          cnt_nxt = lpw_pkg::SLEEP_RESUME_CNT;
        end
      end
      lpw_pkg::ST_REFRESH: begin
        if (cnt_r != '0) begin
          cnt_nxt = cnt_r - 1'b1;
        end else begin
          st_nxt = lpw_pkg::ST_SLEEP;
          rtimer_nxt = refresh_per_r;
        end
        if (sleep_wake) begin
          st_nxt = lpw_pkg::ST_WAKE_SLP;
          cnt_nxt = lpw_pkg::SLEEP_RESUME_CNT;
        end
      end
      lpw_pkg::ST_HIB: begin
        cpu_nxt = 1'b0;
        if (|(wake_hit & wake_mask(st_r))) begin
          st_nxt = lpw_pkg::ST_WAKE_HIB;
          cnt_nxt = lpw_pkg::HIB_RESUME_CNT;
        end
      end
      lpw_pkg::ST_WAKE_SLP, lpw_pkg::ST_WAKE_HIB: begin
        if (cnt_r != '0) begin
          cnt_nxt = cnt_r - 1'b1;
        end
        // Regulator ready, or budget exhausted, ends the wake interval
        if (regulator_ready_i || cnt_r == '0) begin
          st_nxt = lpw_pkg::ST_ACTIVE;
          cpu_nxt = 1'b1;
        end
      end
      default: st_nxt = lpw_pkg::ST_ACTIVE;
    endcase
  end

  // Outputs and boost divider
  always_comb begin
    tirq_nxt = timer_tick_i && wake_en_r[lpw_pkg::WK_TIMER];
    bdiv_nxt = (bdiv_r == '0) ? lpw_pkg::BOOST_DIV_CNT : bdiv_r - 1'b1;
    // Converter oscillator idles in standby
    if (!bact_r) begin
      bdiv_nxt = lpw_pkg::BOOST_DIV_CNT;
    end
    bclk_nxt = bact_r && (bdiv_r == '0);
    ret_nxt = (st_nxt == lpw_pkg::ST_HIB);
    gate_nxt = is_low_power(st_nxt);
    reg_on_nxt = !is_low_power(st_nxt);
    clk12_nxt = !fast_nxt;
    unique case (st_nxt)
      lpw_pkg::ST_SLEEP: bact_nxt = !bstby_r;
      lpw_pkg::ST_HIB: bact_nxt = bhib_r;
      default: bact_nxt = 1'b1;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_r <= lpw_pkg::ST_ACTIVE;
      cnt_r <= '0;
      rtimer_r <= '0;
      refresh_per_r <= lpw_pkg::REFRESH_PERIOD_RST;
      bdiv_r <= '0;
      mode_r <= lpw_pkg::MODE_ACTIVE;
      wake_en_r <= lpw_pkg::WAKE_EN_RST;
      wake_src_r <= '0;
      bsel_r <= lpw_pkg::BST_SEL_RST;
      bstby_r <= 1'b0;
      bhib_r <= 1'b0;
      fast_r <= 1'b0;
      dat_r <= 32'h0;
      ack_r <= 1'b0;
      cpu_r <= 1'b1;
      ret_r <= 1'b0;
      gate_r <= 1'b0;
      reg_on_r <= 1'b1;
      bact_r <= 1'b1;
      bclk_r <= 1'b0;
      tirq_r <= 1'b0;
      tmpl_r <= 1'b1;
      clk12_r <= 1'b1;
    end else begin
      st_r <= st_nxt;
      cnt_r <= cnt_nxt;
      rtimer_r <= rtimer_nxt;
      refresh_per_r <= refresh_per_nxt;
      bdiv_r <= bdiv_nxt;
      mode_r <= mode_nxt;
      wake_en_r <= wake_en_nxt;
      wake_src_r <= wake_src_nxt;
      bsel_r <= bsel_nxt;
      bstby_r <= bstby_nxt;
      bhib_r <= bhib_nxt;
      fast_r <= fast_nxt;
      dat_r <= dat_nxt;
      ack_r <= ack_nxt;
      cpu_r <= cpu_nxt;
      ret_r <= ret_nxt;
      gate_r <= gate_nxt;
      reg_on_r <= reg_on_nxt;
      bact_r <= bact_nxt;
      bclk_r <= bclk_nxt;
      tirq_r <= tirq_nxt;
      tmpl_r <= tmpl_nxt;
      clk12_r <= clk12_nxt;
    end
  end

  assign wb_dat_o = dat_r;
  assign wb_ack_o = ack_r;
  assign global_mode_o = mode_r;
  assign cpu_en_o = cpu_r;
  assign retain_hold_o = ret_r;
  assign periph_gate_o = gate_r;
  assign regulator_on_o = reg_on_r;
  assign boost_output_node_sel_o = bsel_r;
  assign boost_active_o = bact_r;
  assign boost_clk_en_o = bclk_r;
  assign timer_wake_irq_o = tirq_r;
  assign fast_startup_clock_option_o = fast_r;
  assign startup_clk_12m_o = clk12_r;
endmodule

//--- testbench/lpw_props.sv
// Checker for the power-mode controller ports
`timescale 1ns/1ps
module lpw_props (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_ack_o,
  input wire logic pin_irq_i,
  input wire logic [1:0] global_mode_o,
  input wire logic cpu_en_o,
  input wire logic retain_hold_o,
  input wire logic [5:0] boost_output_node_sel_o,
  input wire logic fast_startup_clock_option_o,
  input wire logic startup_clk_12m_o
);
  logic [11:0] quiet_r;
  logic [11:0] quiet_nxt;
  logic [11:0] wake_r;
  logic [11:0] wake_nxt;
  always_comb begin
    quiet_nxt = quiet_r;
    wake_nxt = wake_r;
    if (pin_irq_i) quiet_nxt = 12'h000;
    else if (quiet_r != 12'hFFF) quiet_nxt = quiet_r + 12'h001;
    if (global_mode_o == lpw_pkg::MODE_ACTIVE) wake_nxt = 12'h000;
    else if (wake_r != 12'h000 || (global_mode_o == lpw_pkg::MODE_HIB && pin_irq_i)) wake_nxt = wake_r + 12'h001;
  end
  always_ff @(posedge clk_i) begin
    quiet_r <= rst_i ? 12'h000 : quiet_nxt;
    wake_r <= rst_i ? 12'h000 : wake_nxt;
  end
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  sequence s_slp_pin;
    global_mode_o == lpw_pkg::MODE_SLEEP && pin_irq_i;
  endsequence
  sequence s_hib_quiet;
    $past(global_mode_o) == lpw_pkg::MODE_HIB && quiet_r > 12'd2600;
  endsequence
  a_reset_mode_active: assert property ($past(rst_i) |-> global_mode_o == lpw_pkg::MODE_ACTIVE && cpu_en_o)
    else $error("mode not active after reset");
  a_wake_cpu_on: assert property ($past(global_mode_o) >= 2'h2 && global_mode_o == 2'h0 |-> cpu_en_o)
    else $error("cpu off after wake");
  a_sleep_resume_bound: assert property (s_slp_pin |-> ##[1:376] global_mode_o == lpw_pkg::MODE_ACTIVE)
    else $error("sleep resume too slow");
  a_hib_resume_bound: assert property (wake_r < 12'd2501)
    else $error("hibernate resume too slow");
  a_hib_pin_only: assert property (s_hib_quiet |-> global_mode_o == lpw_pkg::MODE_HIB && retain_hold_o)
    else $error("left hibernate without pin");
  a_boost_sel_max: assert property (boost_output_node_sel_o <= lpw_pkg::BST_SEL_MAX)
    else $error("boost code out of range");
  a_startup_slow_clk: assert property (startup_clk_12m_o == !fast_startup_clock_option_o)
    else $error("startup clock choice wrong");
  a_ack_one_pulse: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o)
    else $error("bus ack not one cycle");
endmodule
bind lpw_ctrl lpw_props i_props (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_ack_o, .pin_irq_i, .global_mode_o,
  .cpu_en_o, .retain_hold_o, .boost_output_node_sel_o, .fast_startup_clock_option_o, .startup_clk_12m_o);

//--- testbench/lpw_reg_model.sv
// Regulator model: ready some cycles after power-on
`timescale 1ns/1ps
module lpw_reg_model #(
  parameter int DLY = 8
) (
  input wire logic clk_i,
  input wire logic on_i,
  input wire logic stuck_i,
  output logic ready_o
);
  int cnt = 0;
  always @(posedge clk_i) begin
    if (!on_i) cnt <= 0;
    else if (cnt < DLY) cnt <= cnt + 1;
  end
  // Never ready while off or held stuck
  assign ready_o = on_i && !stuck_i && cnt >= DLY;
endmodule

//--- testbench/testbench.sv
// Testbench: bus, wake, hibernate and boost scenarios
`timescale 1ns/1ps
module testbench;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic req = 1'b0, we = 1'b0, ready, stuck = 1'b0, tmpl = 1'b1, bclk;
  logic [7:0] adr = 8'h00;
  logic [31:0] wdat = 32'h0, rdat, wb_dat_o;
  logic [6:0] src = 7'h00;
  logic wb_ack_o, cpu_en_o, retain_hold_o, periph_gate_o, regulator_on_o, boost_active_o, timer_wake_irq_o;
  logic fast_startup_clock_option_o, startup_clk_12m_o;
  logic [1:0] global_mode_o;
  logic [5:0] boost_output_node_sel_o;
  int bad_count = 0, num_checks = 0, n;
  always #20 clk_i = ~clk_i;
  lpw_ctrl i_dut (.clk_i, .rst_i, .wb_cyc_i(req), .wb_stb_i(req), .wb_we_i(we), .wb_adr_i(adr), .wb_dat_i(wdat),
    .wb_sel_i(4'hF), .wb_dat_o, .wb_ack_o, .periph_irq_i(src[0]), .supervisor_irq_i(src[1]),
    .timer_tick_i(src[2]), .pin_irq_i(src[3]), .external_reset_pin_i(src[4]), .watchdog_reset_i(src[5]),
    .precise_low_voltage_reset_i(src[6]), .regulator_ready_i(ready), .cpu_template_en_i(tmpl),
    .global_mode_o, .cpu_en_o, .retain_hold_o, .periph_gate_o, .regulator_on_o, .boost_output_node_sel_o,
    .boost_active_o, .boost_clk_en_o(bclk), .timer_wake_irq_o, .fast_startup_clock_option_o, .startup_clk_12m_o);
  lpw_reg_model #(.DLY(8)) i_reg (.clk_i, .on_i(regulator_on_o), .stuck_i(stuck), .ready_o(ready));
  task check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task close_out;
    if (bad_count == 0 && num_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    req <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    do begin
      @(posedge clk_i);
    end while (wb_ack_o !== 1'b1);
    rdat = wb_dat_o;
    req <= 1'b0;
  endtask
  task rd(input logic [7:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    check(rdat, exp);
  endtask
  task pulse(input int i);
    @(posedge clk_i);
    src[i] <= 1'b1;
    @(posedge clk_i);
    src[i] <= 1'b0;
  endtask
  task wait_mode(input int lim);
    n = 0;
    while (global_mode_o !== lpw_pkg::MODE_ACTIVE && n < lim) begin
      @(posedge clk_i);
      n++;
    end
  endtask
  task sleep_wake(input int i, input logic wakes);
    bus(1'b1, lpw_pkg::ADR_MODE, 32'h2);
    pulse(i);
    wait_mode(400);
    check(32'(n < 377), 32'(wakes));
    if (!wakes) pulse(3);
    wait_mode(400);
    check(32'(n < 400), 32'h1);
  endtask
  initial begin
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    rd(lpw_pkg::ADR_WAKE_EN, 32'h7F);
    rd(lpw_pkg::ADR_STATUS, 32'h30);
    rd(8'h20, 32'h0);
    check(boost_output_node_sel_o, 32'h0F);
    bus(1'b1, lpw_pkg::ADR_BOOST, 32'h120);
    check({fast_startup_clock_option_o, startup_clk_12m_o, boost_output_node_sel_o}, 32'hA0);
    bus(1'b1, lpw_pkg::ADR_BOOST, 32'h021);
    rd(lpw_pkg::ADR_BOOST, 32'h020);
    check(startup_clk_12m_o, 32'h1);
    tmpl <= 1'b0;
    repeat (2) @(posedge clk_i);
    check(cpu_en_o, 32'h0);
    while (bclk !== 1'b1) @(posedge clk_i);
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (bclk !== 1'b1 && n < 100);
    check(n, 32'(lpw_pkg::BOOST_DIV_CYC));
    for (int i = 0; i < 7; i++) begin
      stuck <= i[0];
      sleep_wake(i, 1'b1);
      rd(lpw_pkg::ADR_WAKE_SRC, 32'h1 << i);
      check(cpu_en_o, 32'h1);
      bus(1'b1, lpw_pkg::ADR_WAKE_SRC, 32'h7F);
    end
    bus(1'b1, lpw_pkg::ADR_WAKE_EN, 32'h7E);
    sleep_wake(0, 1'b0);
    bus(1'b1, lpw_pkg::ADR_WAKE_EN, 32'h7F);
    pulse(2);
    @(posedge clk_i);
    check(timer_wake_irq_o, 32'h1);
    bus(1'b1, lpw_pkg::ADR_WAKE_EN, 32'h7B);
    pulse(2);
    @(posedge clk_i);
    check(timer_wake_irq_o, 32'h0);
    bus(1'b1, lpw_pkg::ADR_WAKE_EN, 32'h7F);
    stuck <= 1'b1;
    bus(1'b1, lpw_pkg::ADR_MODE, 32'h3);
    for (int i = 0; i < 7; i++) if (i != 3) pulse(i);
    repeat (2700) @(posedge clk_i);
    check({global_mode_o, retain_hold_o, periph_gate_o, regulator_on_o, boost_active_o}, 32'h3C);
    pulse(3);
    wait_mode(2600);
    check(32'(n < 2501), 32'h1);
    stuck <= 1'b0;
    bus(1'b1, lpw_pkg::ADR_REFRESH, 32'h40);
    bus(1'b1, lpw_pkg::ADR_BOOST, 32'h4F);
    bus(1'b1, lpw_pkg::ADR_MODE, 32'h2);
    repeat (5) @(posedge clk_i);
    check(boost_active_o, 32'h0);
    n = 0;
    while (boost_active_o !== 1'b1 && n < 200) begin
      @(posedge clk_i);
      n++;
    end
    check(32'(n < 200), 32'h1);
    pulse(3);
    wait_mode(400);
    repeat (2) @(posedge clk_i);
    check(global_mode_o, 32'h0);
    check(boost_active_o, 32'h1);
    close_out;
  end
  initial begin
    repeat (20000) @(posedge clk_i);
    bad_count++;
    close_out;
  end
endmodule
